// file: inc/pso_pkg.sv
// Constants for the power stage output control block.
// Assumes an 8-bit register port and an extended fuse byte given as an input.
// Operation
// - end-of-cycle interrupt on counter match with reset-B compare, when enabled.
// - end-of-enhanced-cycle interrupt on reset-B match in fifteenth enhanced cycle.
// - capture interrupt on retrigger, counter capture or sync error, when enabled.
// - third unit pin three: generator B when select clear, A when set.
// - third unit pin two: generator A when select clear, B when set.
// - sync source field picks leading/trailing edge of output 0 or 1.
// - ramp number field records ramp of latest interrupt-generating event.
// - end-of-unit flag set on whole cycle; cleared by writing one.
// - forced outputs go low if level fuse is 0, high if 1.
// - reduced outputs forced at reset held until output config written.
// - reset fuses at extended fuse bits seven to three, default one.
// - clock from io or pll clock, divided by 1, 4, 32 or 256.
// - four 12-bit compare values compared continuously with counter.
// - reset-B compare carries 4-bit count of stretched enhanced cycles in upper nibble.
// - compare writes go through shared 8-bit temporary high byte.
// - output enable clear gives port behaviour, set follows generator.
// - third unit config has four output enables at bits 3..0, reset zero.
package pso_pkg;
  localparam int ADDR_W = 4;
  // register map
  localparam logic [3:0] ADDR_THIRD_CFG = 4'h0;
  localparam logic [3:0] ADDR_OUT_CFG = 4'h1;
  localparam logic [3:0] ADDR_CLK_CFG = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
  localparam logic [3:0] ADDR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_CAP_L = 4'h5;
  localparam logic [3:0] ADDR_CAP_H = 4'h6;
  localparam logic [3:0] ADDR_SET_A_L = 4'h8;
  localparam logic [3:0] ADDR_SET_A_H = 4'h9;
  localparam logic [3:0] ADDR_RST_A_L = 4'hA;
  localparam logic [3:0] ADDR_RST_A_H = 4'hB;
  localparam logic [3:0] ADDR_SET_B_L = 4'hC;
  localparam logic [3:0] ADDR_SET_B_H = 4'hD;
  localparam logic [3:0] ADDR_RST_B_L = 4'hE;
  localparam logic [3:0] ADDR_RST_B_H = 4'hF;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  // third unit config fields
  localparam int SEL3_BIT = 7;
  localparam int SEL2_BIT = 6;
  localparam int SYNC_LSB = 4;
  localparam int EN_OUT0_BIT = 0;
  localparam int EN_OUT2_BIT = 1;
  localparam int EN_OUT1_BIT = 2;
  localparam int EN_OUT3_BIT = 3;
  // clock config fields
  localparam int CLKSEL_BIT = 0;
  localparam int PRE_LSB = 1;
  localparam int RUN_BIT = 3;
  // flags / enables
  localparam int EOU_BIT = 0;
  localparam int EC_BIT = 1;
  localparam int EEC_BIT = 2;
  localparam int CAPTURE_EVENT_IRQ_BIT = 3;
  localparam int RAMP_LSB = 6;
  // sync source codes
  localparam logic [1:0] SYNC_LEAD0 = 2'h0;
  localparam logic [1:0] SYNC_TRAIL0 = 2'h1;
  localparam logic [1:0] SYNC_LEAD1 = 2'h2;
  // prescale terminal counts: divide by 1, 4, 32, 256
  localparam logic [7:0] DIV1_LAST = 8'h00;
  localparam logic [7:0] DIV4_LAST = 8'h03;
  localparam logic [7:0] DIV32_LAST = 8'h1F;
  localparam logic [7:0] DIV256_LAST = 8'hFF;
  // extended fuse byte bit positions
  localparam int FUSE_THIRD_RB = 7;
  localparam int FUSE_THIRD_RBA = 6;
  localparam int FUSE_REDUCED_RB = 5;
  localparam int FUSE_LEVEL = 4;
  localparam int FUSE_INPUT_RB = 3;
  localparam logic [7:0] FUSE_DEFAULT = 8'hFA;
  localparam logic [3:0] ENH_LAST = 4'hE;
  localparam int CMP_W = 12;
endpackage

// file: src/power_stage_output_control.sv
// Power stage controller core: counter, compare, waveform, pin routing.
// Assumes one clock, synchronous inputs and an 8-bit register port.
`timescale 1ns/1ps
module power_stage_output_control
  import pso_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // clock source and fuses
  input wire logic pll_tick,
  input wire logic [7:0] ext_fuse,
  // events from outside
  input wire logic fault_a,
  input wire logic fault_b,
  input wire logic retrigger,
  input wire logic capture_req,
  input wire logic sync_error,
  // port fallback values
  input wire logic [1:0] reduced_port_out,
  input wire logic [1:0] reduced_port_oe,
  input wire logic [3:0] third_port_out,
  input wire logic [3:0] third_port_oe,
  // pins
  output logic reduced_out0_pin,
  output logic reduced_out0_oe,
  output logic reduced_out1_pin,
  output logic reduced_out1_oe,
  output logic [1:0] third_unit_out01_pin,
  output logic [1:0] third_unit_out01_oe,
  output logic third_unit_out2_pin,
  output logic third_unit_out2_oe,
  output logic third_unit_out3_pin,
  output logic third_unit_out3_oe,
  // events out
  output logic adc_sync_pulse,
  output logic end_of_cycle_irq,
  output logic end_of_enhanced_cycle_irq,
  output logic capture_event_irq
);

  logic [7:0] third_cfg_r;
  logic [7:0] out_cfg_r;
  logic [7:0] clk_cfg_r;
  logic [7:0] irq_en_r;
  logic [7:0] temp_r;
  logic [15:0] set_a_r;
  logic [15:0] rst_a_r;
  logic [15:0] set_b_r;
  logic [15:0] rst_b_r;
  logic [11:0] cnt_r;
  logic [11:0] cap_r;
  logic [3:0] enh_r;
  logic [1:0] ramp_r;
  logic [1:0] ramp_num_r;
  logic [7:0] div_r;
  logic wave_a_r;
  logic wave_b_r;
  logic eou_r;
  logic ec_r;
  logic eec_r;
  logic capture_event_irq_r;
  logic hold_r;
  logic sync_r;

  logic tick;
  logic src_tick;
  logic [7:0] div_last;
  logic [12:0] top;
  logic cycle_end;
  logic m_set_a;
  logic m_rst_a;
  logic m_set_b;
  logic m_rst_b;
  logic in_mask;
  logic f_a;
  logic f_b;
  logic rtg;
  logic cap_ev;
  logic serr;
  logic ec_ev;
  logic eec_ev;
  logic capture_event_irq_ev;
  logic lead0;
  logic trail0;
  logic lead1;
  logic trail1;
  logic sync_nxt;
  logic w1c_hit;
  logic lvl;

  assign w1c_hit = wr && addr == ADDR_FLAGS;
  assign lvl = ext_fuse[FUSE_LEVEL];

  // configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      third_cfg_r <= CFG_RESET;
      out_cfg_r <= CFG_RESET;
      clk_cfg_r <= CFG_RESET;
      irq_en_r <= CFG_RESET;
    end else if (wr) begin
      case (addr)
        ADDR_THIRD_CFG: third_cfg_r <= wdata;
        ADDR_OUT_CFG: out_cfg_r <= wdata;
        ADDR_CLK_CFG: clk_cfg_r <= wdata;
        ADDR_IRQ_EN: irq_en_r <= wdata;
        default: ;
      endcase
    end
  end

  // compare registers: high byte parks in temp, low byte commits both
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_r <= CFG_RESET;
      set_a_r <= CMP_RESET;
      rst_a_r <= CMP_RESET;
      set_b_r <= CMP_RESET;
      rst_b_r <= CMP_RESET;
    end else if (wr) begin
      case (addr)
        ADDR_SET_A_H, ADDR_RST_A_H, ADDR_SET_B_H, ADDR_RST_B_H: begin
          temp_r <= wdata;
        end
        ADDR_SET_A_L: set_a_r <= {temp_r, wdata};
        ADDR_RST_A_L: rst_a_r <= {temp_r, wdata};
        ADDR_SET_B_L: set_b_r <= {temp_r, wdata};
        ADDR_RST_B_L: rst_b_r <= {temp_r, wdata};
        default: ;
      endcase
    end
  end

  // clock source and prescaler
  assign src_tick = clk_cfg_r[CLKSEL_BIT] ? pll_tick : 1'b1;
  always_comb begin
    case (clk_cfg_r[PRE_LSB +: 2])
      2'h0: div_last = DIV1_LAST;
      2'h1: div_last = DIV4_LAST;
      2'h2: div_last = DIV32_LAST;
      default: div_last = DIV256_LAST;
    endcase
  end
  assign tick = src_tick && div_r == div_last && clk_cfg_r[RUN_BIT];

  always_ff @(posedge clk) begin
    if (rst || !clk_cfg_r[RUN_BIT]) begin
      div_r <= 8'h00;
    end else if (src_tick) begin
      div_r <= (div_r >= div_last) ? 8'h00 : div_r + 8'h01;
    end
  end

  // inputs may be held off while forced outputs are still held
  assign in_mask = !ext_fuse[FUSE_INPUT_RB] && hold_r;
  assign f_a = fault_a && !in_mask;
  assign f_b = fault_b && !in_mask;
  assign rtg = retrigger && !in_mask;
  assign cap_ev = capture_req && !in_mask;
  assign serr = sync_error && !in_mask;

  // compare matches; upper nibble of reset-B stretches early enhanced cycles
  assign m_set_a = tick && cnt_r == set_a_r[CMP_W-1:0];
  assign m_rst_a = tick && cnt_r == rst_a_r[CMP_W-1:0];
  assign m_set_b = tick && cnt_r == set_b_r[CMP_W-1:0];
  assign m_rst_b = tick && cnt_r == rst_b_r[CMP_W-1:0];
  assign top = {1'b0, rst_b_r[CMP_W-1:0]} +
               {12'h000, enh_r < rst_b_r[15:12]};
  assign cycle_end = tick && {1'b0, cnt_r} >= top;

  // counter, enhanced cycle and ramp tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 12'h000;
      enh_r <= 4'h0;
      ramp_r <= 2'h0;
    end else if (rtg) begin
      cnt_r <= 12'h000;
    end else if (cycle_end) begin
      cnt_r <= 12'h000;
      enh_r <= enh_r + 4'h1;
      ramp_r <= ramp_r + 2'h1;
    end else if (tick) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_r <= 12'h000;
    end else if (cap_ev) begin
      cap_r <= cnt_r;
    end
  end

  // waveform generators; reset or fault beats a set on the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      if (m_rst_a || f_a) begin
        wave_a_r <= 1'b0;
      end else if (m_set_a) begin
        wave_a_r <= 1'b1;
      end
      if (m_rst_b || f_b) begin
        wave_b_r <= 1'b0;
      end else if (m_set_b) begin
        wave_b_r <= 1'b1;
      end
    end
  end

  // interrupt events
  assign ec_ev = m_rst_b;
  assign eec_ev = m_rst_b && enh_r == ENH_LAST;
  assign capture_event_irq_ev = rtg || cap_ev || serr;

  // sticky flags: a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      eou_r <= 1'b0;
      ec_r <= 1'b0;
      eec_r <= 1'b0;
      capture_event_irq_r <= 1'b0;
    end else begin
      eou_r <= cycle_end || (eou_r && !(w1c_hit && wdata[EOU_BIT]));
      ec_r <= ec_ev || (ec_r && !(w1c_hit && wdata[EC_BIT]));
      eec_r <= eec_ev || (eec_r && !(w1c_hit && wdata[EEC_BIT]));
      capture_event_irq_r <= capture_event_irq_ev || (capture_event_irq_r && !(w1c_hit && wdata[CAPTURE_EVENT_IRQ_BIT]));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_num_r <= 2'h0;
    end else if ((ec_ev && irq_en_r[EC_BIT]) ||
                 (eec_ev && irq_en_r[EEC_BIT]) ||
                 (capture_event_irq_ev && irq_en_r[CAPTURE_EVENT_IRQ_BIT])) begin
      ramp_num_r <= ramp_r;
    end
  end

  assign end_of_cycle_irq = ec_r && irq_en_r[EC_BIT];
  assign end_of_enhanced_cycle_irq = eec_r && irq_en_r[EEC_BIT];
  assign capture_event_irq = capture_event_irq_r && irq_en_r[CAPTURE_EVENT_IRQ_BIT];

  // adc sync pulse from the chosen edge
  assign lead0 = m_set_a && !(m_rst_a || f_a);
  assign trail0 = m_rst_a || f_a;
  assign lead1 = m_set_b && !(m_rst_b || f_b);
  assign trail1 = m_rst_b || f_b;
  always_comb begin
    case (third_cfg_r[SYNC_LSB +: 2])
      SYNC_LEAD0: sync_nxt = lead0;
      SYNC_TRAIL0: sync_nxt = trail0;
      SYNC_LEAD1: sync_nxt = lead1;
      default: sync_nxt = trail1;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
    end
  end
  assign adc_sync_pulse = sync_r;

  // reduced outputs stay forced after reset until their config is written
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r <= 1'b1;
    end else if (ext_fuse[FUSE_REDUCED_RB] || (wr && addr == ADDR_OUT_CFG)) begin
      hold_r <= 1'b0;
    end
  end

  // pin routing; forcing acts combinationally while reset is high
  always_comb begin
    reduced_out0_pin = out_cfg_r[EN_OUT0_BIT] ? wave_a_r
                                               : reduced_port_out[0];
    reduced_out0_oe = out_cfg_r[EN_OUT0_BIT] | reduced_port_oe[0];
    reduced_out1_pin = out_cfg_r[EN_OUT1_BIT] ? wave_b_r
                                               : reduced_port_out[1];
    reduced_out1_oe = out_cfg_r[EN_OUT1_BIT] | reduced_port_oe[1];
    if ((rst || hold_r) && !ext_fuse[FUSE_REDUCED_RB]) begin
      reduced_out0_pin = lvl;
      reduced_out0_oe = 1'b1;
      reduced_out1_pin = lvl;
      reduced_out1_oe = 1'b1;
    end
  end

  always_comb begin
    third_unit_out01_pin[0] = third_cfg_r[EN_OUT0_BIT] ? wave_a_r
                                                       : third_port_out[0];
    third_unit_out01_oe[0] = third_cfg_r[EN_OUT0_BIT] | third_port_oe[0];
    third_unit_out01_pin[1] = third_cfg_r[EN_OUT1_BIT] ? wave_b_r
                                                       : third_port_out[1];
    third_unit_out01_oe[1] = third_cfg_r[EN_OUT1_BIT] | third_port_oe[1];
    third_unit_out2_pin = !third_cfg_r[EN_OUT2_BIT] ? third_port_out[2] :
      (third_cfg_r[SEL2_BIT] ? wave_b_r : wave_a_r);
    third_unit_out2_oe = third_cfg_r[EN_OUT2_BIT] | third_port_oe[2];
    third_unit_out3_pin = !third_cfg_r[EN_OUT3_BIT] ? third_port_out[3] :
      (third_cfg_r[SEL3_BIT] ? wave_a_r : wave_b_r);
    third_unit_out3_oe = third_cfg_r[EN_OUT3_BIT] | third_port_oe[3];
    if (rst && !ext_fuse[FUSE_THIRD_RB]) begin
      third_unit_out01_pin = {lvl, lvl};
      third_unit_out01_oe = 2'h3;
    end
    if (rst && !ext_fuse[FUSE_THIRD_RBA]) begin
      third_unit_out2_pin = lvl;
      third_unit_out2_oe = 1'b1;
      third_unit_out3_pin = lvl;
      third_unit_out3_oe = 1'b1;
    end
  end

  // read port: data valid in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata <= 8'h00;
    end else begin
      case (addr)
        ADDR_THIRD_CFG: rdata <= third_cfg_r;
        ADDR_OUT_CFG: rdata <= out_cfg_r;
        ADDR_CLK_CFG: rdata <= {4'h0, clk_cfg_r[3:0]};
        ADDR_IRQ_EN: rdata <= {4'h0, irq_en_r[3:0]};
        ADDR_FLAGS: rdata <= {ramp_num_r, 2'h0, capture_event_irq_r, eec_r, ec_r,
                              eou_r};
        ADDR_CAP_L: rdata <= cap_r[7:0];
        ADDR_CAP_H: rdata <= {4'h0, cap_r[11:8]};
        default: rdata <= 8'h00;
      endcase
    end
  end

endmodule

// file: test/pso_monitor.sv
// Port checker for power_stage_output_control.
// Assumes the pso_pkg map; shadows config writes from the bus itself.
`timescale 1ns/1ps
module pso_monitor
  import pso_pkg::*;
(
  // clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // fuses and port values
  input wire logic [7:0] ext_fuse,
  input wire logic [3:0] third_port_out,
  input wire logic [3:0] third_port_oe,
  // pins and events
  input wire logic reduced_out0_pin,
  input wire logic reduced_out0_oe,
  input wire logic [1:0] third_unit_out01_pin,
  input wire logic [1:0] third_unit_out01_oe,
  input wire logic third_unit_out2_pin,
  input wire logic third_unit_out3_pin,
  input wire logic adc_sync_pulse,
  input wire logic end_of_cycle_irq,
  input wire logic capture_event_irq
);
  logic [7:0] cfg_r;
  logic [7:0] en_r;
  logic hold_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= CFG_RESET;
    end else if (wr && addr == ADDR_THIRD_CFG) begin
      cfg_r <= wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      en_r <= 8'h00;
    end else if (wr && addr == ADDR_IRQ_EN) begin
      en_r <= wdata;
    end
  end
  // forced reduced pins outlive reset until the config write
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_r <= !ext_fuse[FUSE_REDUCED_RB];
    end else if (wr && addr == ADDR_OUT_CFG) begin
      hold_r <= 1'b0;
    end
  end
  property p_out3;
    &cfg_r[3:0] |-> third_unit_out3_pin == (cfg_r[SEL3_BIT] ?
      third_unit_out01_pin[0] : third_unit_out01_pin[1]);
  endproperty
  a_out3: assert property (p_out3) else $error("out3 route");
  property p_out2;
    &cfg_r[3:0] |-> third_unit_out2_pin == (cfg_r[SEL2_BIT] ?
      third_unit_out01_pin[1] : third_unit_out01_pin[0]);
  endproperty
  a_out2: assert property (p_out2) else $error("out2 route");
  property p_port;
    !cfg_r[EN_OUT0_BIT] && !$past(rst) |->
      {third_unit_out01_oe[0], third_unit_out01_pin[0]} ==
      {third_port_oe[0], third_port_out[0]};
  endproperty
  a_port: assert property (p_port) else $error("port mode");
  property p_force;
    disable iff (1'b0)
    rst && $past(rst) && !ext_fuse[FUSE_THIRD_RB] |->
      {third_unit_out01_oe, third_unit_out01_pin} ==
      {2'b11, {2{ext_fuse[FUSE_LEVEL]}}};
  endproperty
  a_force: assert property (p_force) else $error("reset force");
  property p_hold;
    hold_r |-> reduced_out0_oe && reduced_out0_pin == ext_fuse[FUSE_LEVEL];
  endproperty
  a_hold: assert property (p_hold) else $error("reduced hold");
  property p_read;
    $past(rd) && $past(addr) == ADDR_THIRD_CFG |-> rdata == $past(cfg_r);
  endproperty
  a_read: assert property (p_read) else $error("cfg read");
  property p_ec;
    $rose(end_of_cycle_irq) |-> en_r[EC_BIT];
  endproperty
  a_ec: assert property (p_ec) else $error("cycle irq");
  property p_capture_event_irq;
    capture_event_irq |-> en_r[CAPTURE_EVENT_IRQ_BIT];
  endproperty
  a_capture_event_irq: assert property (p_capture_event_irq) else $error("capture irq");
  c_ec: cover property ($rose(end_of_cycle_irq));
  c_sync: cover property (adc_sync_pulse);
  c_hold: cover property (hold_r);
endmodule
bind power_stage_output_control pso_monitor i_pso_monitor (
  .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .ext_fuse, .third_port_out,
  .third_port_oe, .reduced_out0_pin, .reduced_out0_oe,
  .third_unit_out01_pin, .third_unit_out01_oe, .third_unit_out2_pin,
  .third_unit_out3_pin, .adc_sync_pulse, .end_of_cycle_irq,
  .capture_event_irq
);

// file: test/switch_stage_model.sv
// Far side: gate inputs of the power switches and the ADC trigger.
// Assumes pull-downs on gate lines, so a released line reads low.
`timescale 1ns/1ps
module switch_stage_model (
  // driven by the block
  input wire logic clk,
  input wire logic [3:0] drv,
  input wire logic [3:0] en,
  input wire logic sync,
  // seen by the bench
  output logic [3:0] pad,
  output int sync_count
);
  assign pad = drv & en;
  initial sync_count = 0;
  always @(posedge clk) begin
    if (sync) begin
      sync_count <= sync_count + 1;
    end
  end
endmodule

// file: test/tb_power_stage_output_control.sv
// Bench: register tasks, pin and event scenarios, reset forcing.
// Assumes the pso_pkg map and the switch model on the third unit pins.
`timescale 1ns/1ps
module tb_power_stage_output_control;
  import pso_pkg::*;
  logic clk, rst, wr, rd, fault_a, fault_b;
  logic pll_tick = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, ext_fuse, v;
  logic [1:0] reduced_port_out, reduced_port_oe;
  logic [1:0] third_unit_out01_pin, third_unit_out01_oe;
  logic [3:0] third_port_out, third_port_oe, pad;
  logic [2:0] ev;
  logic reduced_out0_pin, reduced_out0_oe, reduced_out1_pin, reduced_out1_oe;
  logic third_unit_out2_pin, third_unit_out2_oe;
  logic third_unit_out3_pin, third_unit_out3_oe;
  logic adc_sync_pulse, end_of_cycle_irq, end_of_enhanced_cycle_irq;
  logic capture_event_irq;
  int num_errors, cmp_count, cyc, sc, sn, h[4];
  int dv[4] = '{1, 4, 32, 256};
  logic [7:0] lo[4] = '{8'h02, 8'h05, 8'h03, 8'h09};
  power_stage_output_control i_power_stage_output_control (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pll_tick, .ext_fuse,
    .fault_a, .fault_b, .retrigger(ev[0]), .capture_req(ev[1]),
    .sync_error(ev[2]), .reduced_port_out, .reduced_port_oe,
    .third_port_out, .third_port_oe, .reduced_out0_pin, .reduced_out0_oe,
    .reduced_out1_pin, .reduced_out1_oe, .third_unit_out01_pin,
    .third_unit_out01_oe, .third_unit_out2_pin, .third_unit_out2_oe,
    .third_unit_out3_pin, .third_unit_out3_oe, .adc_sync_pulse,
    .end_of_cycle_irq, .end_of_enhanced_cycle_irq, .capture_event_irq
  );
  switch_stage_model i_switch_stage_model (
    .clk, .sync(adc_sync_pulse), .pad, .sync_count(sc),
    .drv({third_unit_out3_pin, third_unit_out2_pin, third_unit_out01_pin}),
    .en({third_unit_out3_oe, third_unit_out2_oe, third_unit_out01_oe})
  );
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // settle first so a pulse launched under the old setting is not counted
  task automatic measure(input int c, input int w);
    int s0;
    repeat (w) @(posedge clk);
    s0 = sc;
    h = '{0, 0, 0, 0};
    repeat (c) begin
      @(negedge clk);
      for (int k = 0; k < 4; k++) begin
        h[k] += pad[k];
      end
    end
    sn = sc - s0;
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    pll_tick <= !pll_tick;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    {rst, wr, rd, fault_a, fault_b} = 5'h10;
    {addr, wdata, ev} = '0;
    ext_fuse = FUSE_DEFAULT;
    {reduced_port_out, reduced_port_oe} = 4'h6;
    {third_port_out, third_port_oe} = 8'h5A;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg(ADDR_THIRD_CFG);
    check(v, CFG_RESET);
    rreg(4'h7);
    check(v, 8'h00);
    rreg(ADDR_RST_B_L);
    check(v, 8'h00);
    wreg(ADDR_THIRD_CFG, 8'hA5);
    rreg(ADDR_THIRD_CFG);
    check(v, 8'hA5);
    for (int i = 0; i < 4; i++) begin
      wreg(ADDR_SET_A_H + 4'(2 * i), 8'h00);
      wreg(ADDR_SET_A_L + 4'(2 * i), lo[i]);
    end
    wreg(ADDR_IRQ_EN, 8'h0E);
    wreg(ADDR_OUT_CFG, 8'h05);
    wreg(ADDR_CLK_CFG, 8'h08);
    for (int s = 0; s < 4; s++) begin
      wreg(ADDR_THIRD_CFG, {2'(s), 2'(s), 4'hF});
      measure(40, 10);
      check(8'(sn), 8'h04);
      check(8'(h[0]), 8'h0C);
      check(8'(h[1]), 8'h18);
      check(8'(h[2]), s[0] ? 8'h18 : 8'h0C);
      check(8'(h[3]), s[1] ? 8'h0C : 8'h18);
      // only a few cycles so far: enhanced index far from its last value
      if (s == 0) begin
        rreg(ADDR_FLAGS);
        check(v & 8'h06, 8'h02);
      end
    end
    wreg(ADDR_CLK_CFG, 8'h09);
    measure(40, 30);
    check(8'(sn), 8'h02);
    for (int p = 1; p < 4; p++) begin
      wreg(ADDR_CLK_CFG, 8'h08 | 8'(p << 1));
      measure(20 * dv[p], 12 * dv[p]);
      check(8'(sn), 8'h02);
    end
    wreg(ADDR_CLK_CFG, 8'h00);
    rreg(ADDR_FLAGS);
    check(v & 8'h0F, 8'h07);
    check({5'h00, end_of_cycle_irq, end_of_enhanced_cycle_irq,
      capture_event_irq}, 8'h06);
    wreg(ADDR_FLAGS, 8'h07);
    rreg(ADDR_FLAGS);
    check(v & 8'h0F, 8'h00);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({7'h00, capture_event_irq}, 8'h01);
      wreg(ADDR_FLAGS, 8'h08);
      #1 check({7'h00, capture_event_irq}, 8'h00);
    end
    // counter stopped: a part-B fault alone must clear B and fire sync
    sn = sc;
    @(posedge clk);
    fault_b <= 1'b1;
    @(posedge clk);
    fault_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(8'(sc - sn), 8'h01);
    check({7'h00, third_unit_out01_pin[1]}, 8'h00);
    for (int l = 0; l < 2; l++) begin
      @(posedge clk);
      ext_fuse <= {1'b0, l[0], 1'b0, l[0], 4'hA};
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check({4'h0, third_unit_out01_oe, third_unit_out01_pin},
        {6'h03, l[0], l[0]});
      check({4'h0, third_unit_out3_oe, third_unit_out3_pin,
        third_unit_out2_oe, third_unit_out2_pin},
        l[0] ? 8'h09 : 8'h0A);
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({4'h0, reduced_out1_oe, reduced_out1_pin, reduced_out0_oe,
        reduced_out0_pin}, {5'h01, l[0], 1'b1, l[0]});
      wreg(ADDR_OUT_CFG, 8'h00);
      #1 check({4'h0, reduced_out1_oe, reduced_out1_pin, reduced_out0_oe,
        reduced_out0_pin}, 8'h09);
    end
    // first cycle stretched by one count; stop three ticks into ramp two
    wreg(ADDR_RST_B_H, 8'h10);
    wreg(ADDR_RST_B_L, 8'h09);
    wreg(ADDR_IRQ_EN, 8'h02);
    wreg(ADDR_CLK_CFG, 8'h08);
    repeat (22) @(posedge clk);
    wreg(ADDR_CLK_CFG, 8'h00);
    rreg(ADDR_FLAGS);
    check(v & 8'hC0, 8'h40);
    @(posedge clk);
    ev[1] <= 1'b1;
    @(posedge clk);
    ev[1] <= 1'b0;
    rreg(ADDR_CAP_L);
    check(v, 8'h03);
    stop_test();
  end
endmodule
